// file: smbus_host.sv
// behavioural smbus host master driving the sensor serial pins
`timescale 1ns/1ps
`default_nettype none
module smbus_host #(
    parameter logic [6:0] DEV = 7'h18
) (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // clock stands high and data is released between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // ************
    // bit and byte level, 48 ns bit period
    // ************
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        #16 scl = 1'b1;
        #24 r = sda;
        scl = 1'b0;
        #8;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // also serves as repeated start
    task automatic start;
        #1 sda_drv = 1'b1;
        #16 scl = 1'b1;
        #24 sda_drv = 1'b0;
        #24 scl = 1'b0;
        #8;
    endtask
    task automatic stop;
        sda_drv = 1'b0;
        #16 scl = 1'b1;
        #24 sda_drv = 1'b1;
        #24;
    endtask
    // ************
    // transactions
    // ************
    // write byte frame
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] q;
        logic a;
        start;
        xfer({DEV, 1'b0}, q, a);
        xfer(c, q, a);
        xfer(d, q, a);
        stop;
    endtask
    task automatic sb(input logic [7:0] c);
        logic [7:0] q;
        logic a;
        start;
        xfer({DEV, 1'b0}, q, a);
        xfer(c, q, a);
        stop;
    endtask
    // read byte, master nacks the data
    task automatic rd(input logic [7:0] c, output logic [7:0] q);
        logic a;
        start;
        xfer({DEV, 1'b0}, q, a);
        xfer(c, q, a);
        start;
        xfer({DEV, 1'b1}, q, a);
        xfer(8'hFF, q, a);
        stop;
    endtask
    // short read, single master so pointer is safe
    task automatic rx(input logic [6:0] ad, output logic [7:0] q, output logic ok);
        logic a;
        start;
        xfer({ad, 1'b1}, q, ok);
        xfer(8'hFF, q, a);
        stop;
    endtask
endmodule
`default_nettype wire

// file: temp_encode.v
// rounds, clamps and encodes one raw temperature reading
`timescale 1ns/1ps
`default_nettype none
`include "tsense_defines.vh"
module temp_encode #(
    parameter RAW_W = 12
) (
    input wire [RAW_W-1:0] raw_q4,
    input wire shorted,
    output reg [7:0] code
);
    // ****************************************
    // round half up then saturate
    // ****************************************
    reg signed [RAW_W:0] sum;
    reg signed [RAW_W-2:0] whole;
    always @* begin
        sum = $signed({raw_q4[RAW_W-1], raw_q4}) + $signed({{(RAW_W-1){1'b0}}, 2'b10});
        whole = sum[RAW_W:2];
        if (shorted)
            code = 8'h00;
        else if (whole > 127)
            code = `TEMP_MAX_CODE;
        else if (whole < -65)
            code = `TEMP_MIN_CODE;
        else
            code = whole[7:0];
    end
endmodule
`default_nettype wire

// file: tsense_defines.vh
// constants for the two-channel temperature sensor serial front end
`ifndef TSENSE_DEFINES_VH
`define TSENSE_DEFINES_VH
`define CMD_RD_LOC_TEMP 8'h00
`define CMD_RD_REM_TEMP 8'h01
`define CMD_RD_STATUS 8'h02
`define CMD_RD_CONFIG 8'h03
`define CMD_RD_RATE 8'h04
`define CMD_RD_LOC_HI 8'h05
`define CMD_RD_LOC_LO 8'h06
`define CMD_RD_REM_HI 8'h07
`define CMD_RD_REM_LO 8'h08
`define CMD_WR_CONFIG 8'h09
`define CMD_WR_RATE 8'h0A
`define CMD_WR_LOC_HI 8'h0B
`define CMD_WR_LOC_LO 8'h0C
`define CMD_WR_REM_HI 8'h0D
`define CMD_WR_REM_LO 8'h0E
`define CMD_ONE_SHOT 8'h0F
`define CMD_RD_MFG_ID 8'hFE
`define CMD_RD_DEV_ID 8'hFF
`define ALERT_RESP_ADDR 7'h0C
`define HI_LIMIT_RST 8'h7F
`define LO_LIMIT_RST 8'hC9
`define CONFIG_RST 8'h00
`define RATE_RST 8'h02
`define CMD_PTR_RST 8'h00
`define CFG_MASK_BIT 7
`define TEMP_MAX_CODE 8'h7F
`define TEMP_MIN_CODE 8'hBF
`define ST_LOC_HI_BIT 6
`define ST_LOC_LO_BIT 5
`define ST_REM_HI_BIT 4
`define ST_REM_LO_BIT 3
`define ST_OPEN_BIT 2
`define ST_BUSY_BIT 7
`endif

// file: tsense_smbus.v
// serial slave, register file and alarm logic of the temperature sensor
`timescale 1ns/1ps
`default_nettype none
`include "tsense_defines.vh"
module tsense_smbus #(
    parameter RAW_W = 12,
    parameter [6:0] SLAVE_ADDR = 7'h18,
    parameter [7:0] MFG_ID = 8'h5A,  // arbitrary value
    parameter [7:0] DEV_ID = 8'h21   // arbitrary value
) (
    input wire clk_sys,
    input wire resetn,
    input wire scl_in,
    input wire sda_in,
    output reg sda_oe_n,
    output reg alert_oe_n,
    input wire [RAW_W-1:0] loc_raw_q4,
    input wire [RAW_W-1:0] rem_raw_q4,
    input wire conv_start,
    input wire conv_done,
    input wire conv_busy,
    input wire diode_open_det,
    input wire remote_short_det,
    output wire one_shot_req,
    output wire [7:0] config_out,
    output wire [7:0] rate_out
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    reg scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    reg open_m_r, open_s_r;
    always @(posedge clk_sys) begin
        if (!resetn) begin
            scl_m_r <= 1'b1; scl_s_r <= 1'b1; scl_d_r <= 1'b1;
            sda_m_r <= 1'b1; sda_s_r <= 1'b1; sda_d_r <= 1'b1;
            open_m_r <= 1'b0; open_s_r <= 1'b0;
        end else begin
            scl_m_r <= scl_in; scl_s_r <= scl_m_r; scl_d_r <= scl_s_r;
            sda_m_r <= sda_in; sda_s_r <= sda_m_r; sda_d_r <= sda_s_r;
            open_m_r <= diode_open_det; open_s_r <= open_m_r;
        end
    end
    wire scl_rise = scl_s_r & ~scl_d_r;
    wire scl_fall = ~scl_s_r & scl_d_r;
    wire start_ev = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
    wire stop_ev = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;

    // ****************************************
    // temperature encoding
    // ****************************************
    wire [7:0] loc_code, rem_code;
    temp_encode #(.RAW_W(RAW_W)) u_loc (.raw_q4(loc_raw_q4), .shorted(1'b0), .code(loc_code));
    temp_encode #(.RAW_W(RAW_W)) u_rem (.raw_q4(rem_raw_q4), .shorted(remote_short_det), .code(rem_code));

    // ****************************************
    // registers
    // ****************************************
    // two readings and four limit registers
    reg [7:0] loc_temp_r, rem_temp_r, loc_hi_r, loc_lo_r, rem_hi_r, rem_lo_r;
    reg [7:0] config_r, rate_r, cmd_ptr_r;
    reg [4:0] flags_r;
    reg alert_r;
    assign config_out = config_r;
    assign rate_out = rate_r;
    wire [7:0] status = {conv_busy, flags_r[4:1], flags_r[0], 2'b00};

    reg [7:0] rd_data;
    always @* begin
        case (cmd_ptr_r)
            `CMD_RD_LOC_TEMP: rd_data = loc_temp_r;
            `CMD_RD_REM_TEMP: rd_data = rem_temp_r;
            `CMD_RD_STATUS: rd_data = status;
            `CMD_RD_CONFIG: rd_data = config_r;
            `CMD_RD_RATE: rd_data = rate_r;
            `CMD_RD_LOC_HI: rd_data = loc_hi_r;
            `CMD_RD_LOC_LO: rd_data = loc_lo_r;
            `CMD_RD_REM_HI: rd_data = rem_hi_r;
            `CMD_RD_REM_LO: rd_data = rem_lo_r;
            `CMD_RD_MFG_ID: rd_data = MFG_ID;
            `CMD_RD_DEV_ID: rd_data = DEV_ID;
            default: rd_data = 8'h00;
        endcase
    end

    // ****************************************
    // serial slave state machine
    // ****************************************
    localparam S_IDLE = 3'd0, S_ADDR = 3'd1, S_AACK = 3'd2, S_WBYTE = 3'd3;
    localparam S_WACK = 3'd4, S_RBYTE = 3'd5, S_RACK = 3'd6, S_SKIP = 3'd7;
    reg [2:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg [1:0] byte_idx_r;
    reg ara_r;
    reg ack_drive_r;
    reg wr_pulse_r, ptr_pulse_r;
    reg [7:0] wr_cmd_r, wr_data_r;
    reg ara_done_r;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= S_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            byte_idx_r <= 2'd0;
            ara_r <= 1'b0;
            ack_drive_r <= 1'b0;
            sda_oe_n <= 1'b1;
            wr_pulse_r <= 1'b0;
            ptr_pulse_r <= 1'b0;
            wr_cmd_r <= 8'h00;
            wr_data_r <= 8'h00;
            ara_done_r <= 1'b0;
        end else begin
            wr_pulse_r <= 1'b0;
            ptr_pulse_r <= 1'b0;
            ara_done_r <= 1'b0;
            if (stop_ev) begin
                state_r <= S_IDLE;
                sda_oe_n <= 1'b1;
            end else if (start_ev) begin
                state_r <= S_ADDR;
                bit_cnt_r <= 4'h0;
                byte_idx_r <= 2'd0;
                sda_oe_n <= 1'b1;
            end else begin
                case (state_r)
                    S_ADDR, S_WBYTE: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s_r};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            bit_cnt_r <= 4'h0;
                            if (state_r == S_ADDR) begin
                                if (shift_r[7:1] == SLAVE_ADDR) begin
                                    ara_r <= 1'b0;
                                    sda_oe_n <= 1'b0;
                                    state_r <= S_AACK;
                                end else if (shift_r[7:1] == `ALERT_RESP_ADDR && shift_r[0] && alert_r) begin
                                    ara_r <= 1'b1;
                                    sda_oe_n <= 1'b0;
                                    state_r <= S_AACK;
                                end else
                                    state_r <= S_SKIP;
                            end else begin
                                sda_oe_n <= 1'b0;
                                state_r <= S_WACK;
                                if (byte_idx_r == 2'd0) begin
                                    wr_cmd_r <= shift_r;
                                    ptr_pulse_r <= 1'b1;
                                end else begin
                                    wr_data_r <= shift_r;
                                    wr_pulse_r <= 1'b1;
                                end
                                if (byte_idx_r != 2'd3)
                                    byte_idx_r <= byte_idx_r + 2'd1;
                            end
                        end
                    end
                    S_AACK: begin
                        if (scl_fall) begin
                            if (shift_r[0]) begin
                                shift_r <= ara_r ? {SLAVE_ADDR, 1'b1} : rd_data;
                                sda_oe_n <= ara_r ? SLAVE_ADDR[6] : rd_data[7];
                                bit_cnt_r <= 4'h1;
                                state_r <= S_RBYTE;
                            end else begin
                                sda_oe_n <= 1'b1;
                                state_r <= S_WBYTE;
                            end
                        end
                    end
                    S_WACK: begin
                        if (scl_fall) begin
                            sda_oe_n <= 1'b1;
                            state_r <= S_WBYTE;
                        end
                    end
                    S_RBYTE: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == 4'h8) begin
                                sda_oe_n <= 1'b1;
                                state_r <= S_RACK;
                            end else begin
                                sda_oe_n <= shift_r[7 - bit_cnt_r[2:0]];
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            // alert answered, clear whatever the master acks
                            ara_done_r <= ara_r;
                            state_r <= S_SKIP;
                        end
                    end
                    default: sda_oe_n <= 1'b1;
                endcase
            end
        end
    end

    // ****************************************
    // register writes, readings and alarms
    // ****************************************
    // one shot fires on the command byte alone, in any protocol that sends it
    assign one_shot_req = ptr_pulse_r & (shift_r == `CMD_ONE_SHOT);
    wire [3:0] trip = {$signed(loc_temp_r) >= $signed(loc_hi_r), $signed(loc_temp_r) <= $signed(loc_lo_r),
                       $signed(rem_temp_r) >= $signed(rem_hi_r), $signed(rem_temp_r) <= $signed(rem_lo_r)};
    reg started_r;
    always @(posedge clk_sys) begin
        if (!resetn) begin
            loc_hi_r <= `HI_LIMIT_RST;
            rem_hi_r <= `HI_LIMIT_RST;
            loc_lo_r <= `LO_LIMIT_RST;
            rem_lo_r <= `LO_LIMIT_RST;
            loc_temp_r <= 8'h00;
            rem_temp_r <= 8'h00;
            config_r <= `CONFIG_RST;
            rate_r <= `RATE_RST;
            cmd_ptr_r <= `CMD_PTR_RST;
            flags_r <= 5'h00;
            started_r <= 1'b0;
            alert_r <= 1'b0;
            alert_oe_n <= 1'b1;
        end else begin
            if (ptr_pulse_r)
                cmd_ptr_r <= shift_r;
            if (wr_pulse_r) begin
                case (wr_cmd_r)
                    `CMD_WR_CONFIG: config_r <= {shift_r[7:6], 6'h00};
                    `CMD_WR_RATE: rate_r <= shift_r;
                    `CMD_WR_LOC_HI: loc_hi_r <= shift_r;
                    `CMD_WR_LOC_LO: loc_lo_r <= shift_r;
                    `CMD_WR_REM_HI: rem_hi_r <= shift_r;
                    `CMD_WR_REM_LO: rem_lo_r <= shift_r;
                    default: cmd_ptr_r <= cmd_ptr_r;
                endcase
            end
            if (conv_done) begin
                loc_temp_r <= loc_code;
                rem_temp_r <= rem_code;
            end
            if (conv_start) begin
                started_r <= 1'b1;
                flags_r[0] <= open_s_r;
            end
            flags_r[4:1] <= trip;
            if (ara_done_r)
                alert_r <= 1'b0;
            else if (!config_r[`CFG_MASK_BIT] && ((|trip) || (started_r && flags_r[0])))
                alert_r <= 1'b1;
            alert_oe_n <= ~(alert_r & ~ara_done_r);
        end
    end
endmodule
`default_nettype wire

// file: tsense_smbus_asserts.sv
// port-level checks of the sensor serial slave
`timescale 1ns/1ps
`default_nettype none
module tsense_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_oe_n,
    input wire logic alert_oe_n,
    input wire logic one_shot_req,
    input wire logic [7:0] config_out,
    input wire logic [7:0] rate_out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    a_reset_values: assert property ($rose(resetn) |-> sda_oe_n && alert_oe_n && config_out == 8'h00 && rate_out == 8'h02)
        else $error("outputs not at reset values");
    a_mask_holds: assert property (config_out[7] && $past(config_out[7]) && alert_oe_n |=> alert_oe_n)
        else $error("alert raised while masked");
    a_alert_unmasked: assert property ($fell(alert_oe_n) |-> !$past(config_out[7]))
        else $error("alert set with mask bit high");
    a_alert_latched: assert property ((!alert_oe_n && scl_in) [*8] |=> !alert_oe_n)
        else $error("alert released without bus read");
    a_alert_clear_slot: assert property ($rose(alert_oe_n) |-> scl_in)
        else $error("alert cleared outside ack slot");
    a_sda_low_phase: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("sda changed while scl high");
    a_idle_quiet: assert property (scl_in [*8] |=> $stable(config_out) && $stable(rate_out) && $stable(sda_oe_n))
        else $error("outputs moved with bus idle");
    a_one_shot_pulse: assert property (one_shot_req |=> !one_shot_req)
        else $error("one shot request longer than a cycle");
    c_alert_set: cover property ($fell(alert_oe_n));
    c_alert_clear: cover property ($rose(alert_oe_n));
    c_one_shot: cover property (one_shot_req);
endmodule
bind tsense_smbus tsense_chk u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_oe_n(sda_oe_n), .alert_oe_n(alert_oe_n),
    .one_shot_req(one_shot_req), .config_out(config_out), .rate_out(rate_out)
);
`default_nettype wire

// file: tsense_smbus_test.sv
// self-checking bench for the sensor serial slave
`timescale 1ns/1ps
`default_nettype none
`include "tsense_defines.vh"
module tsense_smbus_test;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] loc_raw = 12'h000;
    logic [11:0] rem_raw = 12'h000;
    logic conv_start = 1'b0;
    logic conv_done = 1'b0;
    logic open_det = 1'b0;
    logic short_det = 1'b0;
    wire scl;
    wire sda_drv;
    wire sda_oe_n;
    wire alert_oe_n;
    wire one_shot_req;
    wire [7:0] config_out;
    wire sda = sda_drv & sda_oe_n;
    int num_errors = 0;
    int comparisons = 0;
    int shots = 0;
    logic [7:0] q;
    logic ok;
    // quarter-degree raw reading, expected code
    logic [19:0] rows [8] = '{20'h2087F, 20'h1FA7F, 20'h00201, 20'hFFE00, 20'hFFDFF, 20'hF25C9, 20'hEE8BF, 20'h06519};
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (one_shot_req === 1'b1) shots <= shots + 1;
    tsense_smbus u_tsense_smbus (
        .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_oe_n(sda_oe_n),
        .alert_oe_n(alert_oe_n), .loc_raw_q4(loc_raw), .rem_raw_q4(rem_raw), .conv_start(conv_start),
        .conv_done(conv_done), .conv_busy(1'b0), .diode_open_det(open_det), .remote_short_det(short_det),
        .one_shot_req(one_shot_req), .config_out(config_out), .rate_out()
    );
    smbus_host u_host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
    // ************
    // helpers
    // ************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conv(input logic st);
        @(posedge clk_sys);
        conv_start <= st;
        conv_done <= !st;
        @(posedge clk_sys);
        conv_start <= 1'b0;
        conv_done <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        stop_test;
    end
    // ************
    // main sequence
    // ************
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        open_det <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk({sda_oe_n, alert_oe_n, 6'h00}, 8'hC0);
        chk(config_out, `CONFIG_RST);
        u_host.rx(7'h18, q, ok);
        chk(q, 8'h00);
        u_host.rd(`CMD_RD_STATUS, q);
        chk(q & 8'h04, 8'h00);
        conv(1'b1);
        u_host.rd(`CMD_RD_STATUS, q);
        chk(q & 8'h04, 8'h04);
        @(posedge clk_sys);
        open_det <= 1'b0;
        // let the detector pass its synchroniser
        repeat (3) @(posedge clk_sys);
        conv(1'b1);
        u_host.rd(`CMD_RD_STATUS, q);
        chk(q & 8'h04, 8'h00);
        for (int i = 0; i < 4; i++) begin
            u_host.rd(8'(`CMD_RD_LOC_HI + i), q);
            chk(q, i[0] ? `LO_LIMIT_RST : `HI_LIMIT_RST);
            u_host.wr(8'(`CMD_WR_LOC_HI + i), 8'(8'h3C + i));
            u_host.rd(8'(`CMD_RD_LOC_HI + i), q);
            chk(q, 8'(8'h3C + i));
            u_host.wr(8'(`CMD_WR_LOC_HI + i), i[0] ? `LO_LIMIT_RST : `HI_LIMIT_RST);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            loc_raw <= rows[i][19:8];
            rem_raw <= rows[i][19:8];
            conv(1'b0);
            u_host.rd(`CMD_RD_LOC_TEMP, q);
            chk(q, rows[i][7:0]);
            u_host.rd(`CMD_RD_REM_TEMP, q);
            chk(q, rows[i][7:0]);
        end
        chk({7'h00, alert_oe_n}, 8'h00);
        @(posedge clk_sys);
        short_det <= 1'b1;
        conv(1'b0);
        u_host.rd(`CMD_RD_REM_TEMP, q);
        chk(q, 8'h00);
        u_host.rx(7'h18, q, ok);
        chk(q, 8'h00);
        u_host.rx(`ALERT_RESP_ADDR, q, ok);
        chk(q, 8'h31);
        chk({7'h00, alert_oe_n}, 8'h01);
        u_host.rx(`ALERT_RESP_ADDR, q, ok);
        chk({7'h00, ok}, 8'h00);
        u_host.wr(`CMD_WR_CONFIG, 8'h80);
        chk(config_out, 8'h80);
        @(posedge clk_sys);
        loc_raw <= 12'h208;
        conv(1'b0);
        chk({7'h00, alert_oe_n}, 8'h01);
        u_host.wr(`CMD_WR_CONFIG, 8'h00);
        conv(1'b0);
        chk({7'h00, alert_oe_n}, 8'h00);
        u_host.sb(`CMD_ONE_SHOT);
        for (int i = 0; i < 20 && shots == 0; i++) @(posedge clk_sys);
        chk(8'(shots), 8'h01);
        u_host.rx(7'h19, q, ok);
        chk({7'h00, ok}, 8'h00);
        stop_test;
    end
endmodule
`default_nettype wire
